// file: design/pmou_pkg.sv
// constants, register map and carrier types of the packed multiply/or unit
//------------------------------------------------------------------------
// Contract
// - opcode 0F F5 decodes as multiply-add
// - signed lane products summed pairwise into dwords
// - all-0x8000 pair wraps to 0x80000000, no saturation
// - opcode 0F E5 decodes as multiply-high
// - multiply-high keeps product bits 31..16
// - opcode 0F D5 decodes as multiply-low
// - multiply-low keeps product bits 15..0
// - opcode 0F EB decodes as packed or
// - bit is zero only when both bits zero
// - destination register, source register or memory
// - bad segment address: protection or stack fault
// - page fault with code; alignment fault at level 3
// - task-switched bit gives device unavailable fault
// - pending float error gives float error fault
// - real mode operand past 0FFFFH gives interrupt 13
//------------------------------------------------------------------------
package pmou_pkg;

  // apb register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] MASK_OFS = 12'h008;
  localparam logic [11:0] FAULT_OFS = 12'h00c;
  localparam logic [11:0] RESLO_OFS = 12'h010;
  localparam logic [11:0] RESHI_OFS = 12'h014;

  // control register fields
  localparam int CTRL_PROT_BIT = 0;
  localparam int CTRL_EMU_BIT = 1;
  localparam int CTRL_TS_BIT = 2;
  localparam int CTRL_FPE_BIT = 3;
  localparam int CTRL_CPL_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // status / mask fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // opcode bytes
  localparam logic [7:0] ESC_BYTE = 8'h0f;
  localparam logic [7:0] OPC_MADD = 8'hf5;
  localparam logic [7:0] OPC_MULH = 8'he5;
  localparam logic [7:0] OPC_MULL = 8'hd5;
  localparam logic [7:0] OPC_OR = 8'heb;
  localparam logic [1:0] MOD_REG = 2'h3;

  // fault vectors
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NM = 8'h07;
  localparam logic [7:0] VEC_SS = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_PF = 8'h0e;
  localparam logic [7:0] VEC_MF = 8'h10;
  localparam logic [7:0] VEC_AC = 8'h11;

  localparam logic [1:0] CPL_USER = 2'h3;
  localparam logic [32:0] REAL_LIMIT = 33'h0_0000_ffff;
  localparam logic [32:0] OPND_LAST = 33'h0_0000_0007;

  typedef enum logic [2:0] {
    OP_MADD, OP_MULH, OP_MULL, OP_OR, OP_BAD
  } pmou_op_t;

  // one instruction from the decoder and memory fetch path
  typedef struct packed {
    logic [7:0] escape;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [63:0] dst_val;
    logic [63:0] src_val;
    logic [63:0] mem_val;
    logic [31:0] ea;
    logic seg_bad;
    logic stack_seg;
    logic page_bad;
    logic [31:0] page_code;
    logic misaligned;
  } pmou_req_t;

  typedef struct packed {
    logic [2:0] idx;
    logic [63:0] data;
  } pmou_wb_t;

  typedef struct packed {
    logic [7:0] vector;
    logic has_code;
    logic [31:0] code;
  } pmou_fault_t;

endpackage

// file: design/pmou_unit.sv
// packed multiply/or execution unit with apb control and status
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module pmou_unit
  import pmou_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire pmou_req_t req,
  output logic req_ready,
  output logic wb_valid,
  output pmou_wb_t wb,
  output logic fault_valid,
  output pmou_fault_t fault,
  output logic flags_we,
  output logic irq
);

  //----------------------------------------------------------------------
  // arithmetic helpers
  //----------------------------------------------------------------------
  // signed 16x16 product, used by every multiply lane
  function automatic logic [31:0] mul16s(input logic [15:0] a,
                                         input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return p;
  endfunction

  // full execution of one operation on two 64-bit operands
  function automatic logic [63:0] exec(input pmou_op_t op,
                                       input logic [63:0] d,
                                       input logic [63:0] s);
    logic [63:0] r;
    logic [31:0] p [4];
    r = 64'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = mul16s(d[16*i +: 16], s[16*i +: 16]);
    end
    unique case (op)
      OP_MADD: begin
        // natural 32-bit wrap: all-0x8000 pair gives 0x80000000
        r[31:0] = p[0] + p[1];
        r[63:32] = p[2] + p[3];
      end
      OP_MULH: begin
        for (int i = 0; i < 4; i++) begin
          r[16*i +: 16] = p[i][31:16];
        end
      end
      OP_MULL: begin
        // low half is sign-agnostic, so signed products serve
        for (int i = 0; i < 4; i++) begin
          r[16*i +: 16] = p[i][15:0];
        end
      end
      OP_OR: r = d | s;
      OP_BAD: r = 64'h0;
    endcase
    return r;
  endfunction

  //----------------------------------------------------------------------
  // apb register file
  //----------------------------------------------------------------------
  logic [5:0] ctrl_reg;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata;
  logic addr_ok;
  logic apb_setup;
  logic apb_access;
  logic [1:0] stat_set;
  pmou_fault_t fault_reg;
  pmou_wb_t wb_reg;
  logic wb_valid_reg;
  logic fault_valid_reg;

  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_ok;
  assign prdata = prdata_reg;

  // read mux and address decode
  always_comb begin
    addr_ok = 1'b1;
    rdata = 32'h0;
    unique case (paddr)
      CTRL_OFS: rdata = {26'h0, ctrl_reg};
      STAT_OFS: rdata = {30'h0, stat_reg};
      MASK_OFS: rdata = {30'h0, mask_reg};
      FAULT_OFS: rdata = {23'h0, fault_reg.has_code, fault_reg.vector};
      RESLO_OFS: rdata = wb_reg.data[31:0];
      RESHI_OFS: rdata = wb_reg.data[63:32];
      default: addr_ok = 1'b0;
    endcase
  end

  // read data latched in setup so it is a flop output in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= rdata;
    end
  end

  // control and mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
    end else if (apb_access && pwrite) begin
      if (paddr == CTRL_OFS) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (paddr == MASK_OFS) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // sticky status, cleared by a read; a same-cycle event still lands
  always_comb begin
    stat_next = stat_reg;
    if (apb_access && !pwrite && paddr == STAT_OFS) begin
      stat_next = 2'h0;
    end
    stat_next = stat_next | stat_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  //----------------------------------------------------------------------
  // decode and fault checks
  //----------------------------------------------------------------------
  pmou_op_t op;
  logic from_mem;
  logic prot;
  logic [1:0] cpl;
  logic [32:0] ea_end;
  logic [63:0] src;
  logic flt;
  pmou_fault_t flt_info;

  assign prot = ctrl_reg[CTRL_PROT_BIT];
  assign cpl = ctrl_reg[CTRL_CPL_LSB +: 2];
  // register source when mod selects a register, else memory
  assign from_mem = req.modrm[7:6] != MOD_REG;
  assign src = from_mem ? req.mem_val : req.src_val;
  assign ea_end = {1'b0, req.ea} + OPND_LAST;

  // opcode decode behind the escape byte
  always_comb begin
    op = OP_BAD;
    if (req.escape == ESC_BYTE) begin
      unique case (req.opcode)
        OPC_MADD: op = OP_MADD;
        OPC_MULH: op = OP_MULH;
        OPC_MULL: op = OP_MULL;
        OPC_OR: op = OP_OR;
        default: op = OP_BAD;
      endcase
    end
  end

  // fault priority: opcode/state checks first, then memory checks
  always_comb begin
    flt = 1'b1;
    flt_info = '{vector: VEC_UD, has_code: 1'b0, code: 32'h0};
    if (op == OP_BAD || ctrl_reg[CTRL_EMU_BIT]) begin
      flt_info.vector = VEC_UD;
    end else if (ctrl_reg[CTRL_TS_BIT]) begin
      flt_info.vector = VEC_NM;
    end else if (ctrl_reg[CTRL_FPE_BIT]) begin
      flt_info.vector = VEC_MF;
    end else if (from_mem && !prot && ea_end > REAL_LIMIT) begin
      flt_info.vector = VEC_GP;
    end else if (from_mem && prot && req.seg_bad) begin
      flt_info.has_code = 1'b1;
      flt_info.vector = req.stack_seg ? VEC_SS : VEC_GP;
    end else if (from_mem && prot && req.page_bad) begin
      flt_info.has_code = 1'b1;
      flt_info.vector = VEC_PF;
      flt_info.code = req.page_code;
    end else if (from_mem && prot && req.misaligned && cpl == CPL_USER) begin
      flt_info.has_code = 1'b1;
      flt_info.vector = VEC_AC;
    end else begin
      flt = 1'b0;
    end
  end

  //----------------------------------------------------------------------
  // result and fault outputs, one cycle after the request
  //----------------------------------------------------------------------
  // the unit is fully pipelined, so it never refuses a request
  assign req_ready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_valid_reg <= 1'b0;
      fault_valid_reg <= 1'b0;
    end else begin
      wb_valid_reg <= req_valid & ~flt;
      fault_valid_reg <= req_valid & flt;
    end
  end

  // result kept after a fault so software still sees the last good one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_reg <= '0;
    end else if (req_valid && !flt) begin
      wb_reg.idx <= req.modrm[5:3];
      wb_reg.data <= exec(op, req.dst_val, src);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= '0;
    end else if (req_valid && flt) begin
      fault_reg <= flt_info;
    end
  end

  assign stat_set[STAT_DONE_BIT] = wb_valid_reg;
  assign stat_set[STAT_FAULT_BIT] = fault_valid_reg;
  assign wb_valid = wb_valid_reg;
  assign wb = wb_reg;
  assign fault_valid = fault_valid_reg;
  assign fault = fault_reg;
  // these instructions never touch the flags register
  assign flags_we = 1'b0;

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_clean_req(logic [7:0] opc);
    req_valid && req.escape == ESC_BYTE && req.opcode == opc && !flt;
  endsequence

  a_madd_pairwise: assert property (
    s_clean_req(OPC_MADD) |=> wb_valid && wb.data[31:0] ==
      $past(mul16s(req.dst_val[15:0], src[15:0])
          + mul16s(req.dst_val[31:16], src[31:16])))
    else $error("multiply-add low doubleword wrong");

  a_madd_wrap: assert property (
    s_clean_req(OPC_MADD) ##0 (req.dst_val == {4{16'h8000}}
      && src == {4{16'h8000}}) |=> wb.data == {2{32'h80000000}})
    else $error("multiply-add all-0x8000 wrap wrong");

  a_mulh_lane: assert property (
    s_clean_req(OPC_MULH) |=> wb.data[63:48] ==
      $past(mul16s(req.dst_val[63:48], src[63:48])) >> 16)
    else $error("multiply-high lane wrong");

  a_mull_lane: assert property (
    s_clean_req(OPC_MULL) |=> wb.data[31:16] ==
      16'($past(req.dst_val[31:16] * src[31:16])))
    else $error("multiply-low lane wrong");

  a_or_bits: assert property (
    s_clean_req(OPC_OR) |=> wb.data == $past(req.dst_val | src))
    else $error("packed or result wrong");

  a_emu_faults: assert property (
    req_valid && ctrl_reg[CTRL_EMU_BIT] |=>
      fault_valid && !wb_valid && fault.vector == VEC_UD)
    else $error("emulation bit did not raise invalid opcode");

  a_ts_faults: assert property (
    req_valid && !ctrl_reg[CTRL_EMU_BIT] && op != OP_BAD
      && ctrl_reg[CTRL_TS_BIT] |=> fault.vector == VEC_NM)
    else $error("task-switched bit did not raise fault");

  a_fpe_faults: assert property (
    req_valid && op != OP_BAD && ctrl_reg[2:1] == 2'h0
      && ctrl_reg[CTRL_FPE_BIT] |=> fault.vector == VEC_MF)
    else $error("pending float error not reported");

  a_real_limit: assert property (
    req_valid && op != OP_BAD && ctrl_reg[3:0] == 4'h0 && from_mem
      && req.ea > 32'h0000fff8 |=> fault_valid && fault.vector == VEC_GP)
    else $error("real mode limit fault missing");

  a_page_code: assert property (
    fault_valid && fault.vector == VEC_PF |->
      fault.code == $past(req.page_code))
    else $error("page fault code lost");

  a_no_commit: assert property (
    fault_valid |-> !wb_valid && $stable(wb.data))
    else $error("result committed on a fault");

  a_irq_level: assert property (
    stat_reg[STAT_FAULT_BIT] && mask_reg[STAT_FAULT_BIT] |-> irq)
    else $error("masked-in status did not raise irq");

  a_flags_kept: assert property (
    wb_valid |-> !flags_we)
    else $error("flags written by packed instruction");

  // every request gets exactly one answer, never both
  a_one_answer: assert property (
    req_valid |=> wb_valid != fault_valid)
    else $error("request not answered by exactly one pulse");

  a_madd_high: assert property (
    s_clean_req(OPC_MADD) |=> wb.data[63:32] ==
      $past(mul16s(req.dst_val[47:32], src[47:32])
          + mul16s(req.dst_val[63:48], src[63:48])))
    else $error("multiply-add high doubleword wrong");

  a_mulh_low: assert property (
    s_clean_req(OPC_MULH) |=> wb.data[15:0] ==
      $past(mul16s(req.dst_val[15:0], src[15:0])) >> 16)
    else $error("multiply-high low lane wrong");

  a_mull_low: assert property (
    s_clean_req(OPC_MULL) |=> wb.data[15:0] ==
      16'($past(req.dst_val[15:0] * src[15:0])))
    else $error("multiply-low low lane wrong");

  // segment check: stack segment selects the stack fault, code zero
  a_seg_fault: assert property (
    req_valid && op != OP_BAD && ctrl_reg[3:0] == 4'h1 && from_mem
      && req.seg_bad |=> fault_valid && fault.code == 32'h0
      && fault.vector == ($past(req.stack_seg) ? VEC_SS : VEC_GP))
    else $error("segment fault missing or wrong");

  a_align_fault: assert property (
    req_valid && op != OP_BAD && ctrl_reg == 6'h31 && from_mem
      && !req.seg_bad && !req.page_bad && req.misaligned
      |=> fault_valid && fault.vector == VEC_AC)
    else $error("alignment fault at level 3 missing");

  // decode of the four opcodes behind the escape byte
  a_dec_madd: assert property (
    req.escape == ESC_BYTE && req.opcode == OPC_MADD |-> op == OP_MADD)
    else $error("multiply-add opcode not decoded");

  a_dec_mulh: assert property (
    req.escape == ESC_BYTE && req.opcode == OPC_MULH |-> op == OP_MULH)
    else $error("multiply-high opcode not decoded");

  a_dec_mull: assert property (
    req.escape == ESC_BYTE && req.opcode == OPC_MULL |-> op == OP_MULL)
    else $error("multiply-low opcode not decoded");

  a_dec_or: assert property (
    req.escape == ESC_BYTE && req.opcode == OPC_OR |-> op == OP_OR)
    else $error("packed or opcode not decoded");

  // error response only ever in an access phase
  a_slverr_phase: assert property (
    !apb_access |-> !pslverr)
    else $error("slave error outside access phase");

  // a fault pulse always lands in status, even against a clearing read
  a_status_set: assert property (
    fault_valid |=> stat_reg[STAT_FAULT_BIT])
    else $error("fault status bit not set");

endmodule

// file: dv/pmou_front_model.sv
// front-end model: media register file, decoder and operand fetch
`timescale 1ns/10ps
module pmou_front_model
  import pmou_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire pmou_req_t cmd,
  output logic req_valid,
  output pmou_req_t req,
  input wire logic wb_valid,
  input wire pmou_wb_t wb
);
  logic [63:0] mreg [8];
  // one request per go; idle payload toggles so stale data never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (go) begin
      req_valid <= 1'b1;
      req <= cmd;
      req.dst_val <= mreg[cmd.modrm[5:3]];
      req.src_val <= mreg[cmd.modrm[2:0]];
    end else begin
      req_valid <= 1'b0;
      req <= ~req;
    end
  end
  // results land in the register file only on a commit pulse
  always @(posedge pclk) begin
    if (wb_valid) begin
      mreg[wb.idx] <= wb.data;
    end
  end
endmodule

// file: dv/packed_multiply_or_unit_bench.sv
// self-checking bench for the packed multiply/or unit
`timescale 1ns/10ps
module packed_multiply_or_unit_bench
  import pmou_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go;
  logic req_valid, req_ready, wb_valid, fault_valid, flags_we, irq;
  logic got_wb, got_flt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pmou_req_t cmd, req;
  pmou_wb_t wb;
  pmou_fault_t fault, flt;
  int err_count, total_checks, cyc;

  pmou_unit pmou_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .wb_valid(wb_valid), .wb(wb), .fault_valid(fault_valid),
    .fault(fault), .flags_we(flags_we), .irq(irq));
  pmou_front_model pmou_front_model_i (.pclk(pclk), .presetn(presetn),
    .go(go), .cmd(cmd), .req_valid(req_valid), .req(req),
    .wb_valid(wb_valid), .wb(wb));

  //----------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one apb transfer; waits on pready with no bound of its own, only the cycle ceiling stops a hang
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bad: misaligned, page, stack segment, segment (msb to lsb)
  task automatic exec(input logic [7:0] op, input logic [7:0] modrm,
      input logic [63:0] mem, input logic [31:0] ea, input logic [3:0] bad);
    @(posedge pclk);
    go <= 1'b1;
    cmd <= '{ESC_BYTE, op, modrm, 64'h0, 64'h0, mem, ea, bad[0], bad[1],
      bad[2], 32'h5, bad[3]};
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (wb_valid !== 1'b1 && fault_valid !== 1'b1);
    chk(req_ready, 1'b1);
    got_wb = wb_valid;
    got_flt = fault_valid;
    flt = fault;
    chk(flags_we, 1'b0);
    @(negedge pclk);
  endtask

  // lane-wise reference, worked out independently of the design
  function automatic logic [63:0] ref_op(input logic [7:0] o,
      input logic [63:0] d, input logic [63:0] s);
    logic signed [31:0] p [4];
    logic [63:0] r;
    for (int i = 0; i < 4; i++) begin
      p[i] = $signed(d[16*i+:16]) * $signed(s[16*i+:16]);
      r[16*i+:16] = (o == OPC_MULH) ? p[i][31:16] : p[i][15:0];
    end
    if (o == OPC_MADD) begin
      r = {p[3] + p[2], p[1] + p[0]};
    end
    if (o == OPC_OR) begin
      r = d | s;
    end
    return r;
  endfunction

  //----------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 0);
    chk(rd, 0);
    apb(1'b1, CTRL_OFS, 32'h3f);
    apb(1'b0, CTRL_OFS, 0);
    chk(rd, 32'h3f);
    apb(1'b0, 12'h020, 0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask

  // all four ops on the all-0x8000 wrap case and on mixed signs
  task automatic t_arith();
    logic [63:0] a [2] = '{64'h8000_8000_8000_8000, 64'h7fff_8000_1234_fedc};
    logic [63:0] b [2] = '{64'h8000_8000_8000_8000, 64'h8000_7fff_ffff_0003};
    logic [7:0] op [4] = '{OPC_MADD, OPC_MULH, OPC_MULL, OPC_OR};
    apb(1'b1, CTRL_OFS, 0);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 4; k++) begin
        pmou_front_model_i.mreg[1] = a[j];
        pmou_front_model_i.mreg[2] = b[j];
        exec(op[k], 8'hca, 64'h0, 32'h0, 4'h0);
        chk(pmou_front_model_i.mreg[1], ref_op(op[k], a[j], b[j]));
        apb(1'b0, RESHI_OFS, 0);
        chk(rd, ref_op(op[k], a[j], b[j]) >> 32);
      end
    end
  endtask

  // memory source at the real-mode edge, then unaligned at level 0
  task automatic t_mem();
    pmou_front_model_i.mreg[1] = 64'h0f0f_0000_0000_0001;
    apb(1'b1, CTRL_OFS, 0);
    exec(OPC_OR, 8'h0a, 64'h00f0_0000_8000_0000, 32'hfff8, 4'h0);
    chk(pmou_front_model_i.mreg[1], 64'h0fff_0000_8000_0001);
    apb(1'b1, CTRL_OFS, 32'h01);
    exec(OPC_OR, 8'h0a, 64'h1, 32'h101, 4'h8);
    chk(got_wb, 1'b1);
  endtask

  // each fault: vector, code, no commit, destination untouched
  task automatic t_fault();
    logic [5:0] c [9] = '{6'h03, 6'h05, 6'h09, 6'h00, 6'h01, 6'h01, 6'h01,
      6'h31, 6'h01};
    logic [3:0] bd [9] = '{0, 0, 0, 0, 1, 3, 4, 8, 0};
    logic [7:0] v [9] = '{6, 7, 16, 13, 13, 12, 14, 17, 6};
    for (int i = 0; i < 9; i++) begin
      pmou_front_model_i.mreg[1] = 64'h1234;
      apb(1'b1, CTRL_OFS, c[i]);
      exec((i == 8) ? 8'h74 : OPC_OR, (i > 2 && i < 8) ? 8'h0a : 8'hca,
        64'hff, (i == 3) ? 32'hfff9 : 32'h100, bd[i]);
      chk({got_flt, got_wb, flt.vector}, {2'b10, v[i]});
      chk(flt.code, (i == 6) ? 32'h5 : 32'h0);
      chk(pmou_front_model_i.mreg[1], 64'h1234);
      apb(1'b0, FAULT_OFS, 0);
      chk(rd[7:0], v[i]);
      chk(rd[8], i > 3 && i < 8);
    end
  endtask

  // masked done gives no interrupt; unmasked fault does; read clears
  task automatic t_irq();
    apb(1'b0, STAT_OFS, 0);
    apb(1'b1, MASK_OFS, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h01);
    exec(OPC_OR, 8'hca, 64'h0, 32'h0, 4'h0);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h03);
    exec(OPC_OR, 8'hca, 64'h0, 32'h0, 4'h0);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, STAT_OFS, 0);
    chk(rd, 32'h3);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
  endtask

  // clock, cycle ceiling and the main sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, go} = '0;
    paddr = '0;
    pwdata = '0;
    cmd = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_arith();
    t_mem();
    t_fault();
    t_irq();
    finish_test();
  end
endmodule
